// [logic/rea_accumulator.sv]
`timescale 1ns/1ps
module rea_accumulator
	import rea_pkg::*;
#(
	parameter int WAVE_BASE_DIV = RATE_BASE_DIV
)
(
	input  wire logic             REF_CLK,
	input  wire logic             RST_N,
	input  wire logic [7:0]       ADDR,
	input  wire logic [7:0]       WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output logic      [7:0]       RDATA,
	input  wire logic [PWR_W-1:0] REACTIVE_POWER,
	input  wire logic             ACTIVE_NEGATIVE,
	output logic                  IRQ,
	output logic                  WAVE_STROBE
);
	typedef struct packed {
		logic [7:0]       wave_sel;
		logic [7:0]       creep_mode;
		logic [7:0]       acc_mode;
		logic [7:0]       en_one;
		logic [7:0]       en_three;
		logic [7:0]       st_one;
		logic [7:0]       st_three;
		logic [7:0]       divider;
		logic [ACC_W-1:0] acc;
		logic [2:0]       step;
		logic             prev_neg;
		logic             have_prev;
		logic             creep;
		logic             neg_act;
		logic [7:0]       wave_cnt;
		logic [PWR_W-1:0] wave_data;
		logic [7:0]       rdata;
		logic             wave_stb;
	} rea_state_s;

	rea_state_s st_q;
	rea_state_s st_d;

	rea_div_if div ();

	// Divider runs once per accumulation step on the magnitude of power.
	rea_divider u_div (
		.REF_CLK (REF_CLK),
		.RST_N   (RST_N),
		.div     (div.slave)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Threshold for a selector code; zero means detection is off.
	function automatic logic [PWR_W-1:0] creep_level(input logic [1:0] sel);
		case (sel)
			2'h1:    creep_level = CREEP_T1;
			2'h2:    creep_level = CREEP_T2;
			2'h3:    creep_level = CREEP_T3;
			default: creep_level = '0;
		endcase
	endfunction

	// Which byte of a 24-bit word a register address selects.
	function automatic logic [7:0] pick(input logic [23:0] w, input rea_byte_e b);
		case (b)
			SEL_HI:  pick = w[23:16];
			SEL_MID: pick = w[15:8];
			default: pick = w[7:0];
		endcase
	endfunction

	logic [PWR_W-1:0] mag;
	logic             pwr_neg;
	logic             step_tick;
	logic [ACC_W-1:0] addend;
	logic [ACC_W-1:0] acc_new;
	logic [VIS_W-1:0] vis_old;
	logic [VIS_W-1:0] vis_new;
	logic             do_sub;
	logic [7:0]       rd_byte;
	logic             rclr_lo;
	logic             abs_mode;
	logic             tamp_mode;
	logic [7:0]       rate_lim;

	// sign taken from the two's complement MSB.
	assign pwr_neg  = REACTIVE_POWER[PWR_W-1];
	assign mag      = pwr_neg ? PWR_W'(-REACTIVE_POWER) : REACTIVE_POWER;
	assign step_tick = (st_q.step == 3'(STEP_CYCLES - 1));
	assign abs_mode  = st_q.acc_mode[BIT_ACC_ABSOLUTE];
	assign tamp_mode = st_q.acc_mode[BIT_ACC_ANTITAMP];

	assign div.start    = step_tick;
	assign div.dividend = mag;
	assign div.divisor  = st_q.divider;
	assign addend       = {{(ACC_W-PWR_W){1'b0}}, div.quotient};

	// Direction of the add, by mode; absolute overrides antitamper.
	always_comb begin
		if (abs_mode) begin
			do_sub = 1'b0;
		end else if (tamp_mode) begin
			do_sub = st_q.neg_act ^ st_q.prev_neg;
		end else begin
			do_sub = st_q.prev_neg;
		end
	end

	assign acc_new = do_sub ? st_q.acc - addend : st_q.acc + addend;
	assign vis_old = st_q.acc[ACC_W-1 -: VIS_W];
	assign vis_new = acc_new[ACC_W-1 -: VIS_W];
	assign rclr_lo = RD && (ADDR == ADDR_RCLR_LO);
	assign rate_lim = 8'(WAVE_BASE_DIV << st_q.wave_sel[LSB_WAVE_RATE +: 2]);

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	// Multi-byte values are read high byte first; the low byte of the
	// read-clear word triggers the clear, so software reads it last.
	always_comb begin
		case (ADDR)
			ADDR_WAVE_SEL:    rd_byte = st_q.wave_sel;
			ADDR_CREEP_MODE:  rd_byte = st_q.creep_mode;
			ADDR_ACC_MODE:    rd_byte = st_q.acc_mode;
			ADDR_IRQ_EN_ONE:  rd_byte = st_q.en_one;
			ADDR_IRQ_EN_THR:  rd_byte = st_q.en_three;
			ADDR_IRQ_ST_ONE:  rd_byte = st_q.st_one;
			ADDR_IRQ_ST_THR:  rd_byte = st_q.st_three;
			ADDR_DIVIDER:     rd_byte = st_q.divider;
			ADDR_ENERGY_HI,
			ADDR_RCLR_HI:     rd_byte = pick(vis_old, SEL_HI);
			ADDR_ENERGY_MID,
			ADDR_RCLR_MID:    rd_byte = pick(vis_old, SEL_MID);
			ADDR_ENERGY_LO,
			ADDR_RCLR_LO:     rd_byte = pick(vis_old, SEL_LO);
			ADDR_WAVE_DATA_H: rd_byte = pick(st_q.wave_data, SEL_HI);
			ADDR_WAVE_DATA_M: rd_byte = pick(st_q.wave_data, SEL_MID);
			ADDR_WAVE_DATA_L: rd_byte = pick(st_q.wave_data, SEL_LO);
			default:          rd_byte = RESET_BYTE; // Unmapped reads as zero.
		endcase
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.wave_stb = 1'b0;
		st_d.rdata = RD ? rd_byte : RESET_BYTE;

		// Software clears first so that a same-cycle event below wins.
		if (WR) begin
			case (ADDR)
				ADDR_WAVE_SEL:   st_d.wave_sel = WDATA;
				ADDR_CREEP_MODE: st_d.creep_mode = WDATA;
				ADDR_ACC_MODE:   st_d.acc_mode = WDATA;
				ADDR_IRQ_EN_ONE: st_d.en_one = WDATA;
				ADDR_IRQ_EN_THR: st_d.en_three = WDATA;
				ADDR_IRQ_ST_ONE: st_d.st_one = st_q.st_one & ~WDATA;
				ADDR_IRQ_ST_THR: st_d.st_three = st_q.st_three & ~WDATA;
				ADDR_DIVIDER:    st_d.divider = WDATA;
				default:         st_d.divider = st_q.divider;
			endcase
		end

		// Five-cycle step timer.
		st_d.step = step_tick ? 3'h0 : st_q.step + 3'h1;

		// Sample power once per step; compare with the previous sample.
		if (step_tick) begin
			st_d.prev_neg  = pwr_neg;
			st_d.have_prev = 1'b1;
			st_d.neg_act   = ACTIVE_NEGATIVE;
			st_d.creep = (creep_level(st_q.creep_mode[LSB_CREEP_SEL +: 2]) != '0)
				&& (mag < creep_level(st_q.creep_mode[LSB_CREEP_SEL +: 2]));
			if (st_q.have_prev && (st_q.prev_neg != pwr_neg)) begin
				if (st_q.acc_mode[BIT_ACC_SIGN_POL] ? !pwr_neg : pwr_neg) begin
					st_d.st_one[BIT_ST_SIGN] = 1'b1;
				end
			end
		end

		// Creep flag re-asserts every cycle while the condition holds.
		if (st_q.creep) begin
			st_d.st_one[BIT_ST_CREEP] = 1'b1;
		end

		// Add the divided sample unless the load is below threshold.
		if (div.done && !st_q.creep) begin
			st_d.acc = acc_new;
			// Top two visible bits: 00 to 01 or 11 to 10 is half full, 01 and 10 swapping is a wrap.
			if ((vis_old[VIS_W-1 -: 2] == 2'h0 && vis_new[VIS_W-1 -: 2] == 2'h1)
				|| (vis_old[VIS_W-1 -: 2] == 2'h3 && vis_new[VIS_W-1 -: 2] == 2'h2)) begin
				st_d.st_one[BIT_ST_HALF] = 1'b1;
			end
			if ((vis_old[VIS_W-1 -: 2] == 2'h1 && vis_new[VIS_W-1 -: 2] == 2'h2)
				|| (vis_old[VIS_W-1 -: 2] == 2'h2 && vis_new[VIS_W-1 -: 2] == 2'h1)) begin
				st_d.st_one[BIT_ST_OVER] = 1'b1;
			end
		end

		// Read-clear empties the visible bits, keeping the hidden fraction.
		if (rclr_lo) begin
			st_d.acc[ACC_W-1 -: VIS_W] = '0;
			if (div.done && !st_q.creep) begin
				st_d.acc[ACC_W-1 -: VIS_W] = VIS_W'(vis_new - vis_old);
			end
		end

		// Waveform sampler, rate set by a power-of-two divider of steps.
		if (step_tick) begin
			if (st_q.wave_cnt >= rate_lim - 8'h01) begin
				st_d.wave_cnt = 8'h00;
				if (st_q.wave_sel[LSB_WAVE_SRC +: 3] == WAVE_SRC_REACTIVE
					&& st_q.en_three[BIT_EN3_WAVE]) begin
					st_d.wave_data = REACTIVE_POWER;
					st_d.wave_stb  = 1'b1;
					st_d.st_three[BIT_ST3_WAVE] = 1'b1;
				end
			end else begin
				st_d.wave_cnt = st_q.wave_cnt + 8'h01;
			end
		end
	end

	// State register; all modes reset to off.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Level interrupt held while any enabled flag stands.
	assign IRQ = |(st_q.st_one & st_q.en_one) | |(st_q.st_three & st_q.en_three);
	assign RDATA = st_q.rdata;
	assign WAVE_STROBE = st_q.wave_stb;
endmodule

// [logic/rea_pkg.sv]
package rea_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_WAVE_SEL    = 8'h0d;
	localparam logic [7:0] ADDR_CREEP_MODE  = 8'h0e;
	localparam logic [7:0] ADDR_ACC_MODE    = 8'h0f;
	localparam logic [7:0] ADDR_IRQ_EN_ONE  = 8'hd9;
	localparam logic [7:0] ADDR_IRQ_EN_THR  = 8'hdb;
	localparam logic [7:0] ADDR_IRQ_ST_ONE  = 8'hdc;
	localparam logic [7:0] ADDR_ENERGY_HI   = 8'he0;
	localparam logic [7:0] ADDR_ENERGY_MID  = 8'he1;
	localparam logic [7:0] ADDR_ENERGY_LO   = 8'he2;
	localparam logic [7:0] ADDR_RCLR_HI     = 8'he4;
	localparam logic [7:0] ADDR_RCLR_MID    = 8'he5;
	localparam logic [7:0] ADDR_RCLR_LO     = 8'he6;
	localparam logic [7:0] ADDR_DIVIDER     = 8'he8;
	localparam logic [7:0] ADDR_IRQ_ST_THR  = 8'he9;
	localparam logic [7:0] ADDR_WAVE_DATA_H = 8'hea;
	localparam logic [7:0] ADDR_WAVE_DATA_M = 8'heb;
	localparam logic [7:0] ADDR_WAVE_DATA_L = 8'hec;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_ACC_SIGN_POL  = 4;
	localparam int BIT_ACC_ANTITAMP  = 5;
	localparam int BIT_ACC_ABSOLUTE  = 6;
	localparam int LSB_CREEP_SEL     = 2;
	localparam int LSB_WAVE_SRC      = 0;
	localparam int LSB_WAVE_RATE     = 3;
	localparam int BIT_ST_SIGN       = 1;
	localparam int BIT_ST_CREEP      = 2;
	localparam int BIT_ST_HALF       = 3;
	localparam int BIT_ST_OVER       = 4;
	localparam int BIT_ST3_WAVE      = 0;
	localparam int BIT_EN3_WAVE      = 0;
	localparam logic [2:0] WAVE_SRC_REACTIVE = 3'h2;

	// ---------------------------------------------------------------
	// Widths, reset values and timing
	// ---------------------------------------------------------------
	localparam int ACC_W    = 49;
	localparam int VIS_W    = 24;
	localparam int PWR_W    = 24;
	localparam int STEP_CYCLES  = 5;
	localparam int RATE_BASE_DIV = 8;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// No-load thresholds as fractions of full scale, in parts per 2**24.
	localparam logic [23:0] CREEP_T1 = 24'h000a12;
	localparam logic [23:0] CREEP_T2 = 24'h000509;
	localparam logic [23:0] CREEP_T3 = 24'h00026d;

	// Which byte of a 24-bit word a register index selects.
	typedef enum {SEL_HI, SEL_MID, SEL_LO} rea_byte_e;

endpackage

// [logic/rea_div_if.sv]
`timescale 1ns/1ps
interface rea_div_if;
	import rea_pkg::*;
	logic                     start;
	logic [PWR_W-1:0]         dividend;
	logic [7:0]               divisor;
	logic                     done;
	logic [PWR_W-1:0]         quotient;
	modport master (output start, output dividend, output divisor,
			input done, input quotient);
	modport slave  (input start, input dividend, input divisor,
			output done, output quotient);
endinterface

// [logic/rea_divider.sv]
`timescale 1ns/1ps
// Unsigned restoring divider, all quotient bits in the cycle after start.
// A bit-serial loop would need PWR_W cycles, but a new sample starts it every
// accumulation step, so it would be restarted before it could finish.
// A divisor of zero is treated as one, so the quotient equals the dividend.
module rea_divider
	import rea_pkg::*;
(
	input  wire logic REF_CLK,
	input  wire logic RST_N,
	rea_div_if.slave  div
);
	typedef struct packed {
		logic [PWR_W-1:0] quo;
		logic [PWR_W-1:0] num;
		logic [7:0]       den;
		logic             busy;
		logic             done;
	} rea_div_s;

	rea_div_s         st_q;
	rea_div_s         st_d;
	logic [PWR_W:0]   trial;
	logic [PWR_W-1:0] rem_w;
	logic [PWR_W-1:0] quo_w;

	// ---------------------------------------------------------------
	// Iteration
	// ---------------------------------------------------------------
	// Shift-subtract loop unrolled over every quotient bit.
	// The remainder stays below the 8-bit divisor, so the top bit of the trial is the borrow.
	always_comb begin
		rem_w = '0;
		quo_w = '0;
		trial = '0;
		for (int i = PWR_W - 1; i >= 0; i--) begin
			trial = {rem_w, st_q.num[i]} - {{(PWR_W-7){1'b0}}, st_q.den};
			if (!trial[PWR_W]) begin
				rem_w    = trial[PWR_W-1:0];
				quo_w[i] = 1'b1;
			end else begin
				rem_w = {rem_w[PWR_W-2:0], st_q.num[i]};
			end
		end
	end

	// Latch the operands on start; the quotient is registered one cycle later.
	always_comb begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (div.start) begin
			st_d.num  = div.dividend;
			st_d.den  = (div.divisor == 8'h00) ? 8'h01 : div.divisor;
			st_d.busy = 1'b1;
		end else if (st_q.busy) begin
			st_d.quo  = quo_w;
			st_d.busy = 1'b0;
			st_d.done = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign div.done     = st_q.done;
	assign div.quotient = st_q.quo;
endmodule

// [tb/rea_chk_properties.sv]
`timescale 1ns/1ps
// Watches the accumulator ports and mirrors its mode and enable writes.
module rea_chk
	import rea_pkg::*;
#(
	parameter int WAVE_BASE_DIV = RATE_BASE_DIV
)
(
	input wire logic             REF_CLK,
	input wire logic             RST_N,
	input wire logic [7:0]       ADDR,
	input wire logic [7:0]       WDATA,
	input wire logic             WR,
	input wire logic             RD,
	input wire logic [7:0]       RDATA,
	input wire logic [PWR_W-1:0] REACTIVE_POWER,
	input wire logic             ACTIVE_NEGATIVE,
	input wire logic             IRQ,
	input wire logic             WAVE_STROBE
);
	logic [7:0] en1_q;
	logic [7:0] en3_q;
	logic [7:0] acc_q;
	logic [7:0] crp_q;
	// ----------
	// Shadows
	// ----------
	// Mirrored so that the sign and creep properties know which single source may raise the line.
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			en1_q <= 8'h00;
			en3_q <= 8'h00;
			acc_q <= 8'h00;
			crp_q <= 8'h00;
		end else if (WR) begin
			if (ADDR == ADDR_IRQ_EN_ONE) en1_q <= WDATA;
			if (ADDR == ADDR_IRQ_EN_THR) en3_q <= WDATA;
			if (ADDR == ADDR_ACC_MODE) acc_q <= WDATA;
			if (ADDR == ADDR_CREEP_MODE) crp_q <= WDATA;
		end
	end
	// Zero counts as neither sign, so it never starts a transition.
	wire pos = !REACTIVE_POWER[PWR_W-1] && (REACTIVE_POWER != '0);
	wire neg = REACTIVE_POWER[PWR_W-1];
	wire sgn_only = (en1_q == 8'h02) && (en3_q == 8'h00);
	wire crp_only = (en1_q == 8'h04) && (en3_q == 8'h00);
	// ----------
	// Properties
	// ----------
	default clocking dc @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_N);
	property p_mode_rb;
		WR && ADDR == ADDR_ACC_MODE ##1 RD && ADDR == ADDR_ACC_MODE
			|=> RDATA[6:4] == $past(WDATA[6:4], 2);
	endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode readback differs");
	property p_irq_hold;
		IRQ && !WR |=> IRQ;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
	property p_irq_quiet;
		en1_q == 8'h00 && en3_q == 8'h00 |-> !IRQ;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("irq while disabled");
	property p_strobe_gap;
		WAVE_STROBE |=> !WAVE_STROBE [*4];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobe too soon");
	property p_sign_fall;
		pos [*6] ##1 (neg && sgn_only && !acc_q[BIT_ACC_SIGN_POL]) [*6] |-> ##[0:4] IRQ;
	endproperty
	a_sign_fall: assert property (p_sign_fall) else $error("no fall flag");
	property p_sign_rise;
		neg [*6] ##1 (pos && sgn_only && acc_q[BIT_ACC_SIGN_POL]) [*6] |-> ##[0:4] IRQ;
	endproperty
	a_sign_rise: assert property (p_sign_rise) else $error("no rise flag");
	property p_creep;
		(REACTIVE_POWER == '0 && crp_only && crp_q[3:2] != 2'b00) [*8] |-> ##[0:6] IRQ;
	endproperty
	a_creep: assert property (p_creep) else $error("no creep flag");
	property p_rclr;
		RD && ADDR == ADDR_RCLR_LO ##1 RD && ADDR == ADDR_ENERGY_HI
			|=> RDATA == 8'h00 || RDATA == 8'hff;
	endproperty
	a_rclr: assert property (p_rclr) else $error("energy not cleared");
	c_irq: cover property ($rose(IRQ));
	c_wave: cover property (WAVE_STROBE);
	c_rclr: cover property (RD && ADDR == ADDR_RCLR_LO);
endmodule

// [tb/rea_power_src.sv]
`timescale 1ns/1ps
// Stands in for the filter datapath; slow mode only moves every fourth cycle.
module rea_power_src
	import rea_pkg::*;
(
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic [PWR_W-1:0] target,
	input wire logic             tgt_neg,
	input wire logic             slow,
	output logic     [PWR_W-1:0] power,
	output logic                 act_neg
);
	logic [1:0] div_q;
	// Signed two's complement output held as a level between updates.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 2'h0;
			power <= '0;
			act_neg <= 1'b0;
		end else begin
			div_q <= div_q + 2'h1;
			if (!slow || div_q == 2'h3) begin
				power <= target;
				act_neg <= tgt_neg;
			end
		end
	end
endmodule

// [tb/test_rea_accumulator.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; $display("unexpected %s exp %0h got %0h", n, e, g); end end
module test_rea_accumulator;
	import rea_pkg::*;
	localparam logic [23:0] P = 24'h7fffff;
	localparam logic [23:0] N = 24'h800001;
	logic        REF_CLK = 1'b0;
	logic        RST_N = 1'b0;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic        slow = 1'b0;
	logic        tneg = 1'b0;
	logic [7:0]  ADDR = 8'h00;
	logic [7:0]  WDATA = 8'h00;
	logic [23:0] tgt = 24'h000000;
	logic [7:0]  RDATA;
	logic [23:0] pw;
	logic        an;
	logic        IRQ;
	logic        WAVE_STROBE;
	int          err_total = 0;
	int          samples_checked = 0;
	always #25 REF_CLK = ~REF_CLK;
	rea_power_src rea_power_src_i (.clk(REF_CLK), .rst_n(RST_N), .target(tgt),
		.tgt_neg(tneg), .slow(slow), .power(pw), .act_neg(an));
	rea_accumulator #(.WAVE_BASE_DIV(2)) rea_accumulator_i (.REF_CLK, .RST_N, .ADDR,
		.WDATA, .WR, .RD, .RDATA, .REACTIVE_POWER(pw), .ACTIVE_NEGATIVE(an), .IRQ,
		.WAVE_STROBE);
	// ----------
	// Bus tasks
	// ----------
	// A write leaves one idle cycle behind it, so strobes never overlap.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge REF_CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= d;
		@(posedge REF_CLK);
		WR <= 1'b0;
	endtask
	// Back-to-back reads; each byte stands in the cycle after its strobe is
	// sampled, so it is taken two edges after the strobe was raised.
	task automatic rds(input logic [7:0] al[$], output logic [71:0] v);
		v = '0;
		for (int i = 0; i <= al.size() + 1; i++) begin
			@(posedge REF_CLK);
			if (i > 1) v = {v[63:0], RDATA};
			RD <= (i < al.size());
			if (i < al.size()) ADDR <= al[i];
		end
	endtask
	task automatic s_reset;
		logic [71:0] v;
		rds('{ADDR_ACC_MODE, ADDR_CREEP_MODE, ADDR_IRQ_EN_ONE, 8'h00}, v);
		`CHK("reset regs", 32'h0, v[31:0])
	endtask
	// Rates are judged over a long window since the add pipeline hides phase.
	task automatic s_accum;
		logic [71:0] v;
		longint e;
		int dv[6] = '{0, 0, 0, 0, 0, 4};
		int sg[6] = '{1, -1, 1, 1, 1, -1};
		logic [7:0] md[6] = '{8'h00, 8'h00, 8'h40, 8'h60, 8'h20, 8'h20};
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_ACC_MODE, md[i]);
			wr(ADDR_DIVIDER, 8'(dv[i]));
			tgt <= (i == 0) ? P : N;
			tneg <= (i == 4);
			repeat (40) @(posedge REF_CLK);
			rds('{ADDR_RCLR_HI, ADDR_RCLR_MID, ADDR_RCLR_LO}, v);
			repeat (4000) @(posedge REF_CLK);
			rds('{ADDR_ENERGY_HI, ADDR_ENERGY_MID, ADDR_ENERGY_LO, ADDR_RCLR_HI,
				ADDR_RCLR_MID, ADDR_RCLR_LO, ADDR_ENERGY_HI, ADDR_ENERGY_MID,
				ADDR_ENERGY_LO}, v);
			e = sg[i] * 800 * longint'(P) / ((dv[i] == 0 ? 1 : dv[i]) * 64'sd33554432);
			`CHK("energy", 1'b1, ($signed(v[71:48]) - e) inside {[-3:3]})
			`CHK("rclr", 1'b1, ($signed(v[47:24]) - $signed(v[71:48])) inside {[-1:1]})
			`CHK("cleared", 1'b1, $signed(v[23:0]) inside {[-1:1]})
		end
		wr(ADDR_DIVIDER, 8'h00);
		wr(ADDR_ACC_MODE, 8'h00);
	endtask
	task automatic s_sign;
		logic [71:0] v;
		wr(ADDR_IRQ_ST_ONE, 8'hff);
		wr(ADDR_IRQ_EN_ONE, 8'h02);
		tgt <= P;
		repeat (20) @(posedge REF_CLK);
		`CHK("irq rise p0", 1'b0, IRQ)
		tgt <= N;
		repeat (20) @(posedge REF_CLK);
		`CHK("irq fall p0", 1'b1, IRQ)
		rds('{ADDR_IRQ_ST_ONE}, v);
		`CHK("sign flag", 1'b1, v[BIT_ST_SIGN])
		wr(ADDR_IRQ_ST_ONE, 8'h02);
		repeat (2) @(posedge REF_CLK);
		`CHK("irq cleared", 1'b0, IRQ)
		@(posedge REF_CLK);
		WR <= 1'b1;
		ADDR <= ADDR_ACC_MODE;
		WDATA <= 8'h10;
		@(posedge REF_CLK);
		WR <= 1'b0;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		@(posedge REF_CLK);
		`CHK("mode", 8'h10, RDATA & 8'h70)
		slow <= 1'b1;
		tgt <= P;
		repeat (20) @(posedge REF_CLK);
		`CHK("irq rise p1", 1'b1, IRQ)
		wr(ADDR_IRQ_ST_ONE, 8'h02);
		tgt <= N;
		repeat (20) @(posedge REF_CLK);
		`CHK("irq fall p1", 1'b0, IRQ)
		slow <= 1'b0;
		wr(ADDR_IRQ_EN_ONE, 8'h00);
		wr(ADDR_ACC_MODE, 8'h00);
	endtask
	task automatic s_creep;
		tgt <= 24'h000000;
		repeat (20) @(posedge REF_CLK);
		wr(ADDR_IRQ_ST_ONE, 8'hff);
		wr(ADDR_IRQ_EN_ONE, 8'h04);
		for (int s = 0; s < 4; s++) begin
			wr(ADDR_CREEP_MODE, 8'(s << LSB_CREEP_SEL));
			repeat (12) @(posedge REF_CLK);
			wr(ADDR_IRQ_ST_ONE, 8'h04);
			repeat (12) @(posedge REF_CLK);
			`CHK("creep irq", 1'(s != 0), IRQ)
		end
		wr(ADDR_CREEP_MODE, 8'h00);
		wr(ADDR_IRQ_EN_ONE, 8'h00);
	endtask
	task automatic s_wave;
		logic [71:0] v;
		int n;
		tgt <= 24'h123456;
		wr(ADDR_IRQ_EN_THR, 8'h01);
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_WAVE_SEL, 8'((r << LSB_WAVE_RATE) | WAVE_SRC_REACTIVE));
			repeat (40) @(posedge REF_CLK);
			n = 0;
			repeat (400) begin
				@(posedge REF_CLK);
				if (WAVE_STROBE === 1'b1) n++;
			end
			`CHK("strobes", 1'b1, (n - 400 / (10 << r)) inside {[-1:1]})
		end
		rds('{ADDR_WAVE_DATA_H, ADDR_WAVE_DATA_M, ADDR_WAVE_DATA_L}, v);
		`CHK("wave data", 24'h123456, v[23:0])
		wr(ADDR_IRQ_EN_THR, 8'h00);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Cuts a hang short and reports it as a mismatch.
	initial begin
		repeat (60000) @(posedge REF_CLK);
		err_total++;
		results();
	end
	initial begin
		repeat (4) @(posedge REF_CLK);
		RST_N <= 1'b1;
		s_reset();
		s_accum();
		s_sign();
		s_creep();
		s_wave();
		results();
	end
endmodule
bind rea_accumulator rea_chk #(.WAVE_BASE_DIV(WAVE_BASE_DIV)) rea_chk_i (.REF_CLK, .RST_N,
	.ADDR, .WDATA, .WR, .RD, .RDATA, .REACTIVE_POWER, .ACTIVE_NEGATIVE, .IRQ, .WAVE_STROBE);
